// ### logic/fcr_map.svh
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH
// ==================================================
// Register offsets (word index on the register port)
`define FCR_REG_CTRL 8'h00
`define FCR_REG_PLL_MULT 8'h01
`define FCR_REG_TEMP_CODE 8'h02
`define FCR_REG_TEMP_REF 8'h03
`define FCR_REG_TEMP_SLOPE 8'h04
`define FCR_REG_STATUS 8'h05
`define FCR_REG_CTX_ADDR 8'h06
`define FCR_REG_CTX_DATA 8'h07
`define FCR_REG_SET_A 8'h10
`define FCR_REG_SET_B 8'h20
// ==================================================
// Control register bits
`define FCR_CTRL_STREAM 0
`define FCR_CTRL_SLAVE 1
`define FCR_CTRL_CTX_B 2
`define FCR_CTRL_EMB 3
`define FCR_CTRL_STATS 4
`define FCR_CTRL_HDR 5
// ==================================================
// Entries of each switchable set
`define FCR_SET_EXP 0
`define FCR_SET_EXP2 1
`define FCR_SET_LINE_LEN 2
`define FCR_SET_ROWS 3
`define FCR_SET_VBLANK 4
`define FCR_SET_AGAIN 5
`define FCR_SET_AGAIN_T1 6
`define FCR_SET_DG_RED 7
`define FCR_SET_DG_GR1 8
`define FCR_SET_DG_GR2 9
`define FCR_SET_DG_BLUE 10
`define FCR_SET_MODE 11
// Readout mode bits
`define FCR_MODE_COL_BIN 0
`define FCR_MODE_ROW_BIN 1
`define FCR_MODE_X_SKIP 2
`define FCR_MODE_Y_SKIP 3
`define FCR_MODE_ROW_SUM 4
// ==================================================
// Reset values and fixed counts
`define FCR_RST_LINE_LEN 16'h0010
`define FCR_RST_ROWS 16'h0008
`define FCR_RST_VBLANK 16'h0002
`define FCR_RST_GAIN 16'h0010
`define FCR_RST_PLL_MULT 16'h0020
`define FCR_GAIN_MIN 16'h0010
`define FCR_GAIN_MAX 16'h0100
`define FCR_EXTRA_ROWS 16'h0002
`endif

// ### logic/fcr_pkg.sv
package fcr_pkg;
    localparam int FCR_NSET = 12;

    typedef enum logic [2:0] {
        FCR_PH_IDLE = 3'b000,
        FCR_PH_WAIT = 3'b001,
        FCR_PH_EMB = 3'b010,
        FCR_PH_ACT = 3'b011,
        FCR_PH_STAT = 3'b100,
        FCR_PH_BLANK = 3'b101
    } fcr_phase_e;

    typedef enum logic [1:0] {
        FCR_ROW_NONE = 2'b00,
        FCR_ROW_EMB = 2'b01,
        FCR_ROW_ACT = 2'b10,
        FCR_ROW_STAT = 2'b11
    } fcr_row_e;

    typedef logic [FCR_NSET-1:0][15:0] fcr_set_t;

    // Settings in force for the frame being read out
    typedef struct packed {
        logic [15:0] exp_rows;
        logic [15:0] exp2_rows;
        logic [15:0] line_len;
        logic [15:0] again;
        logic [15:0] again_t1;
        logic [3:0][15:0] dgain;
        logic col_bin;
        logic row_bin;
        logic row_sum;
        logic x_skip;
        logic y_skip;
    } fcr_params_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } fcr_req_s;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] pll;
        logic [15:0] ctx_addr;
        logic [1:0] [FCR_NSET-1:0][15:0] sets;
        logic [15:0] rd_data;
        logic [2:0] trig_sync;
        logic [15:0] temp_s0;
        logic [15:0] temp_s1;
        fcr_phase_e phase;
        logic [15:0] row_cyc;
        logic [15:0] row_idx;
        logic exp_sel;
        logic oth_pend;
        logic oth_sel;
        logic frame_start;
        logic [7:0] frame_cnt;
        fcr_params_s params;
    } fcr_state_s;
endpackage

// ### logic/fcr_frame_ctx.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "fcr_map.svh"

// Overview of operation
// RQ1 - With embedded data on, two embedded rows precede the first active row.
// RQ2 - With statistics on, two statistics rows follow the last active row.
// RQ3 - In slave mode a trigger edge starts each frame readout.
// RQ4 - A 256 x 16 context memory holds stored register changes.
// RQ5 - Software stores the same register list in every context.
// RQ6 - One select bit picks set A or set B of switchable registers.
// RQ7 - After an A to B change in frame n, exposure switches in n+1.
// RQ8 - Other switchable registers take new-context values at frame n+2.
// RQ9 - B back to A uses the same staged timing.
// RQ10 - Analog gain spans 1x to 16x, shared by all colour channels.
// RQ11 - Digital gain spans 1x to 16x, separate for each colour channel.
// RQ12 - Line-interleaved mode gives each exposure its own analog gain.
// RQ13 - Horizontal binning combines two same-colour pixels in digital readout.
// RQ14 - Vertical binning combines two same-colour rows in pixel readout.
// RQ15 - Skipping by two, horizontal and vertical set independently.
// RQ16 - Horizontal skipping keeps the row period unchanged.
// RQ17 - Vertical skipping reads fewer rows and shortens the frame.
// RQ18 - Row summing only on monochrome variants; colour variants bin only.
// RQ19 - An odd PLL multiplier M is used as M-1.
// RQ20 - Software keeps the PLL on when the serial pixel output is used.
// RQ21 - Temperature code readable with reference point and slope.
// RQ22 - Context select sampled once per frame at readout start.
// RQ23 - With extra rows disabled, active rows follow frame start directly.
module fcr_frame_ctx import fcr_pkg::*; #(
    parameter int CTX_DEPTH = 256,
    parameter bit MONO = 1'b0,
    parameter logic [15:0] TEMP_REF = 16'h0400,
    parameter logic [15:0] TEMP_SLOPE = 16'h0010
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic trigger_in,
    input wire logic [15:0] temp_code_in,
    output logic frame_start,
    output logic row_valid,
    output fcr_row_e row_kind,
    output logic [15:0] row_num,
    output logic [15:0] pll_mult_eff,
    output fcr_params_s params
);

    // ==================================================
    // Helpers
    function automatic logic [15:0] clamp_gain(input logic [15:0] g);
        if (g < `FCR_GAIN_MIN) begin
            return `FCR_GAIN_MIN;
        end else if (g > `FCR_GAIN_MAX) begin
            return `FCR_GAIN_MAX;
        end
        return g;
    endfunction

    function automatic logic [15:0] at_least_one(input logic [15:0] v);
        return (v == 16'h0000) ? 16'h0001 : v;
    endfunction

    // Bank word check; the upper byte must be zero, bit 5 picks bank B
    function automatic logic is_set_addr(input logic [15:0] a);
        return a[15:8] == 8'h00 && a[3:0] < 4'(FCR_NSET) && (a[7:4] == 4'h1 || a[7:4] == 4'h2);
    endfunction

    // ==================================================
    // State
    fcr_state_s st_ff;
    fcr_state_s nxt_st;
    fcr_req_s req;
    logic [15:0] ctx_mem [CTX_DEPTH];
    logic trig_edge;
    logic go;
    logic row_end;
    logic [15:0] act_rows;
    logic ctx_wr;
    fcr_set_t oth_set;
    fcr_set_t exp_set;
    logic [15:0] mode;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign trig_edge = st_ff.trig_sync[1] & ~st_ff.trig_sync[2];
    assign oth_set = st_ff.sets[st_ff.oth_sel];
    assign exp_set = st_ff.sets[st_ff.exp_sel];
    assign mode = oth_set[`FCR_SET_MODE];
    // Line length is the row period; x skip never touches it
    assign row_end = st_ff.row_cyc == at_least_one(oth_set[`FCR_SET_LINE_LEN]) - 16'h0001; // RQ16
    // Vertical skip or bin halves the rows read out
    assign act_rows = at_least_one((mode[`FCR_MODE_Y_SKIP] | mode[`FCR_MODE_ROW_BIN])
        ? {1'b0, oth_set[`FCR_SET_ROWS][15:1]} : oth_set[`FCR_SET_ROWS]); // RQ17 RQ14
    assign ctx_wr = req.wr && req.addr[7:0] == `FCR_REG_CTX_DATA; // RQ4

    // Frame start: free-running after blanking, or on trigger in slave mode
    always_comb begin
        go = 1'b0;
        if (st_ff.ctrl[`FCR_CTRL_STREAM]) begin
            case (st_ff.phase)
                FCR_PH_IDLE: go = !st_ff.ctrl[`FCR_CTRL_SLAVE];
                FCR_PH_WAIT: go = trig_edge; // RQ3
                FCR_PH_BLANK: go = row_end && !st_ff.ctrl[`FCR_CTRL_SLAVE]
                    && st_ff.row_idx == at_least_one(oth_set[`FCR_SET_VBLANK]) - 16'h0001;
                default: go = 1'b0;
            endcase
        end
    end

    // ==================================================
    // Next-state logic
    always_comb begin
        nxt_st = st_ff;
        nxt_st.frame_start = 1'b0;
        nxt_st.trig_sync = {st_ff.trig_sync[1:0], trigger_in};
        nxt_st.temp_s0 = temp_code_in;
        nxt_st.temp_s1 = st_ff.temp_s0;

        // Register writes
        if (req.wr) begin
            case (req.addr[7:0])
                `FCR_REG_CTRL: nxt_st.ctrl = req.wdata;
                `FCR_REG_PLL_MULT: nxt_st.pll = req.wdata;
                `FCR_REG_CTX_ADDR: nxt_st.ctx_addr = req.wdata;
                `FCR_REG_CTX_DATA: nxt_st.ctx_addr = st_ff.ctx_addr + 16'h0001; // RQ4
                default: begin
                    // Two banks of switchable registers, A and B
                    if (is_set_addr(req.addr)) begin
                        nxt_st.sets[req.addr[5]][req.addr[3:0]] = req.wdata; // RQ6
                    end
                end
            endcase
        end

        // Register reads, answered in the next cycle; unmapped reads zero
        nxt_st.rd_data = 16'h0000;
        if (req.rd) begin
            case (req.addr[7:0])
                `FCR_REG_CTRL: nxt_st.rd_data = st_ff.ctrl;
                `FCR_REG_PLL_MULT: nxt_st.rd_data = st_ff.pll;
                `FCR_REG_TEMP_CODE: nxt_st.rd_data = st_ff.temp_s1; // RQ21
                `FCR_REG_TEMP_REF: nxt_st.rd_data = TEMP_REF; // RQ21
                `FCR_REG_TEMP_SLOPE: nxt_st.rd_data = TEMP_SLOPE; // RQ21
                `FCR_REG_STATUS: nxt_st.rd_data = {st_ff.frame_cnt, 2'b00, st_ff.oth_sel,
                    st_ff.exp_sel, 1'b0, st_ff.phase};
                `FCR_REG_CTX_ADDR: nxt_st.rd_data = st_ff.ctx_addr;
                `FCR_REG_CTX_DATA: nxt_st.rd_data = ctx_mem[st_ff.ctx_addr[$clog2(CTX_DEPTH)-1:0]];
                default: begin
                    if (is_set_addr(req.addr)) begin
                        nxt_st.rd_data = st_ff.sets[req.addr[5]][req.addr[3:0]];
                    end
                end
            endcase
        end

        // Row timer runs in every readout phase
        if (st_ff.phase != FCR_PH_IDLE && st_ff.phase != FCR_PH_WAIT) begin
            nxt_st.row_cyc = row_end ? 16'h0000 : st_ff.row_cyc + 16'h0001;
            nxt_st.row_idx = row_end ? st_ff.row_idx + 16'h0001 : st_ff.row_idx;
        end

        // Frame sequencer
        case (st_ff.phase)
            FCR_PH_IDLE: begin
                if (st_ff.ctrl[`FCR_CTRL_STREAM] && st_ff.ctrl[`FCR_CTRL_SLAVE]) begin
                    nxt_st.phase = FCR_PH_WAIT; // RQ3
                end
            end
            FCR_PH_WAIT: begin
                // Leaving slave mode must not strand the sequencer here
                if (!st_ff.ctrl[`FCR_CTRL_STREAM] || !st_ff.ctrl[`FCR_CTRL_SLAVE]) begin
                    nxt_st.phase = FCR_PH_IDLE;
                end
            end
            FCR_PH_EMB: begin
                if (row_end && st_ff.row_idx == `FCR_EXTRA_ROWS - 16'h0001) begin
                    nxt_st.phase = FCR_PH_ACT; // RQ1
                    nxt_st.row_idx = 16'h0000;
                end
            end
            FCR_PH_ACT: begin
                if (row_end && st_ff.row_idx == act_rows - 16'h0001) begin
                    nxt_st.phase = st_ff.ctrl[`FCR_CTRL_STATS] ? FCR_PH_STAT : FCR_PH_BLANK; // RQ2 RQ23
                    nxt_st.row_idx = 16'h0000;
                end
            end
            FCR_PH_STAT: begin
                if (row_end && st_ff.row_idx == `FCR_EXTRA_ROWS - 16'h0001) begin
                    nxt_st.phase = FCR_PH_BLANK; // RQ2
                    nxt_st.row_idx = 16'h0000;
                end
            end
            FCR_PH_BLANK: begin
                if (row_end && st_ff.row_idx == at_least_one(oth_set[`FCR_SET_VBLANK]) - 16'h0001) begin
                    nxt_st.phase = !st_ff.ctrl[`FCR_CTRL_STREAM] ? FCR_PH_IDLE
                        : (st_ff.ctrl[`FCR_CTRL_SLAVE] ? FCR_PH_WAIT : FCR_PH_BLANK);
                end
            end
            default: nxt_st.phase = FCR_PH_IDLE;
        endcase

        // Frame boundary: staged context pipeline, select sampled only here
        if (go) begin
            nxt_st.phase = st_ff.ctrl[`FCR_CTRL_EMB] ? FCR_PH_EMB : FCR_PH_ACT; // RQ1 RQ23
            nxt_st.row_cyc = 16'h0000;
            nxt_st.row_idx = 16'h0000;
            nxt_st.frame_start = 1'b1;
            nxt_st.frame_cnt = st_ff.frame_cnt + 8'h01;
            nxt_st.exp_sel = st_ff.ctrl[`FCR_CTRL_CTX_B]; // RQ7 RQ9 RQ22
            nxt_st.oth_pend = st_ff.ctrl[`FCR_CTRL_CTX_B]; // RQ22
            nxt_st.oth_sel = st_ff.oth_pend; // RQ8 RQ9
        end

        // Settings in force; summing is withheld on colour parts
        nxt_st.params.exp_rows = exp_set[`FCR_SET_EXP]; // RQ7
        nxt_st.params.exp2_rows = exp_set[`FCR_SET_EXP2]; // RQ7
        nxt_st.params.line_len = at_least_one(oth_set[`FCR_SET_LINE_LEN]); // RQ16
        nxt_st.params.again = clamp_gain(oth_set[`FCR_SET_AGAIN]); // RQ10
        nxt_st.params.again_t1 = st_ff.ctrl[`FCR_CTRL_HDR]
            ? clamp_gain(oth_set[`FCR_SET_AGAIN_T1]) : clamp_gain(oth_set[`FCR_SET_AGAIN]); // RQ12
        for (int c = 0; c < 4; c++) begin
            nxt_st.params.dgain[c] = clamp_gain(oth_set[`FCR_SET_DG_RED + c]); // RQ11
        end
        nxt_st.params.col_bin = mode[`FCR_MODE_COL_BIN]; // RQ13
        nxt_st.params.row_bin = mode[`FCR_MODE_ROW_BIN]; // RQ14
        nxt_st.params.row_sum = mode[`FCR_MODE_ROW_SUM] & MONO; // RQ18
        nxt_st.params.x_skip = mode[`FCR_MODE_X_SKIP]; // RQ15
        nxt_st.params.y_skip = mode[`FCR_MODE_Y_SKIP]; // RQ15
    end

    // ==================================================
    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
            for (int s = 0; s < 2; s++) begin
                st_ff.sets[s][`FCR_SET_LINE_LEN] <= `FCR_RST_LINE_LEN;
                st_ff.sets[s][`FCR_SET_ROWS] <= `FCR_RST_ROWS;
                st_ff.sets[s][`FCR_SET_VBLANK] <= `FCR_RST_VBLANK;
                st_ff.sets[s][`FCR_SET_AGAIN] <= `FCR_RST_GAIN;
                st_ff.sets[s][`FCR_SET_AGAIN_T1] <= `FCR_RST_GAIN;
                for (int c = 0; c < 4; c++) begin
                    st_ff.sets[s][`FCR_SET_DG_RED + c] <= `FCR_RST_GAIN;
                end
            end
            st_ff.pll <= `FCR_RST_PLL_MULT;
            st_ff.params.line_len <= `FCR_RST_LINE_LEN;
            st_ff.params.again <= `FCR_RST_GAIN;
            st_ff.params.again_t1 <= `FCR_RST_GAIN;
            st_ff.params.dgain <= {4{`FCR_RST_GAIN}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Context memory; contents are not cleared by reset, software loads it
    always_ff @(posedge core_clk) begin
        if (ctx_wr) begin
            ctx_mem[st_ff.ctx_addr[$clog2(CTX_DEPTH)-1:0]] <= req.wdata; // RQ4
        end
    end

    // ==================================================
    // Outputs
    assign reg_rdata = st_ff.rd_data;
    assign frame_start = st_ff.frame_start;
    assign row_valid = st_ff.phase inside {FCR_PH_EMB, FCR_PH_ACT, FCR_PH_STAT};
    assign row_kind = (st_ff.phase == FCR_PH_EMB) ? FCR_ROW_EMB
        : (st_ff.phase == FCR_PH_ACT) ? FCR_ROW_ACT
        : (st_ff.phase == FCR_PH_STAT) ? FCR_ROW_STAT : FCR_ROW_NONE;
    assign row_num = st_ff.row_idx;
    // Odd multiplier drops to the even value below
    assign pll_mult_eff = {st_ff.pll[15:1], 1'b0}; // RQ19
    assign params = st_ff.params;

    // ==================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_emb_two;
        (st_ff.phase == FCR_PH_EMB && nxt_st.phase == FCR_PH_ACT) |-> st_ff.row_idx == 16'h0001 && row_end;
    endproperty
    a_emb_two: assert property (p_emb_two) else $error("embedded rows not two"); // RQ1

    property p_stat_two;
        (st_ff.phase == FCR_PH_STAT && nxt_st.phase == FCR_PH_BLANK) |-> st_ff.row_idx == 16'h0001;
    endproperty
    a_stat_two: assert property (p_stat_two) else $error("statistics rows not two"); // RQ2

    property p_slave_start;
        (st_ff.phase == FCR_PH_WAIT && st_ff.ctrl[`FCR_CTRL_STREAM] && trig_edge) |=> frame_start && row_valid;
    endproperty
    a_slave_start: assert property (p_slave_start) else $error("trigger did not start frame"); // RQ3

    property p_no_trig_no_start;
        (st_ff.phase == FCR_PH_WAIT && !trig_edge) |=> !frame_start;
    endproperty
    a_no_trig_no_start: assert property (p_no_trig_no_start) else $error("slave frame without trigger"); // RQ3

    property p_exp_next;
        frame_start |-> st_ff.exp_sel == $past(st_ff.ctrl[`FCR_CTRL_CTX_B]);
    endproperty
    a_exp_next: assert property (p_exp_next) else $error("exposure context not taken at boundary"); // RQ7

    property p_oth_lag;
        frame_start |-> st_ff.oth_sel == $past(st_ff.oth_pend);
    endproperty
    a_oth_lag: assert property (p_oth_lag) else $error("other registers not one frame behind"); // RQ8

    property p_sel_stable;
        !go |=> $stable(st_ff.exp_sel) && $stable(st_ff.oth_sel);
    endproperty
    a_sel_stable: assert property (p_sel_stable) else $error("context changed mid frame"); // RQ22

    property p_no_extra;
        (go && !st_ff.ctrl[`FCR_CTRL_EMB]) |=> row_kind == FCR_ROW_ACT && row_num == 16'h0000;
    endproperty
    a_no_extra: assert property (p_no_extra) else $error("rows inserted before active rows"); // RQ23

    property p_gain_range;
        ##1 params.again >= `FCR_GAIN_MIN && params.again <= `FCR_GAIN_MAX && params.dgain[0] <= `FCR_GAIN_MAX;
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain outside 1x to 16x"); // RQ10

    property p_pll_even;
        req.wr && req.addr[7:0] == `FCR_REG_PLL_MULT |=> pll_mult_eff == ($past(req.wdata) & 16'hFFFE);
    endproperty
    a_pll_even: assert property (p_pll_even) else $error("PLL multiplier not made even"); // RQ19

    property p_sum_mono;
        params.row_sum |-> MONO;
    endproperty
    a_sum_mono: assert property (p_sum_mono) else $error("summing on colour part"); // RQ18

    c_slave_frame: cover property (st_ff.phase == FCR_PH_WAIT ##1 frame_start);
    c_emb_frame: cover property (row_kind == FCR_ROW_EMB ##[1:300] row_kind == FCR_ROW_ACT);
    c_ctx_swap: cover property (frame_start && st_ff.oth_sel != st_ff.exp_sel);
endmodule // fcr_frame_ctx

// ### verif/fcr_trig_model.sv
`timescale 1ns/10ps
// ==========
// External sync controller: drives the frame trigger pin
module fcr_trig_model (
    input wire logic core_clk,
    output logic trigger_in
);
    initial trigger_in = 1'b0;
    // One pulse; held several cycles so the synchroniser cannot miss it
    task automatic fire(input int lead, input int width);
        repeat (lead) @(posedge core_clk);
        trigger_in <= 1'b1;
        repeat (width) @(posedge core_clk);
        trigger_in <= 1'b0;
    endtask
endmodule // fcr_trig_model

// ### verif/frame_context_readout_control_bench.sv
`timescale 1ns/10ps
`include "fcr_map.svh"
module frame_context_readout_control_bench import fcr_pkg::*;;
    typedef logic [10:0][15:0] fcr_exp_t;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] temp_code_in = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata, row_num, pll_mult_eff, t, r1, r2;
    logic trigger_in, frame_start, row_valid, rd_seen, in_fr;
    fcr_row_e row_kind, lastk;
    fcr_params_s params;
    int miscompares = 0;
    int cmp_count = 0;
    logic [31:0] rng = 32'h1781;
    logic hdr = 1'b1;
    logic [15:0] sv [2][FCR_NSET];
    logic [15:0] cnt [3];
    logic [15:0] oerr;
    logic [15:0] rdq [$];
    fcr_exp_t frq [$];
    fcr_exp_t got;
    string fn [11] = '{"emb", "act", "stat", "exp", "llen", "ag", "ag_t1", "dg_r", "dg_b", "mode", "order"};

    fcr_frame_ctx #(.CTX_DEPTH(256), .MONO(1'b0), .TEMP_REF(16'h0123), .TEMP_SLOPE(16'h0045)) uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_in(trigger_in),
        .temp_code_in(temp_code_in), .frame_start(frame_start), .row_valid(row_valid),
        .row_kind(row_kind), .row_num(row_num), .pll_mult_eff(pll_mult_eff), .params(params));
    fcr_trig_model u_trig (.core_clk(core_clk), .trigger_in(trigger_in));

    // ==========
    // Clock
    always #10 core_clk = ~core_clk;

    // ==========
    // Helpers
    function automatic logic [15:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[15:0];
    endfunction
    function automatic logic [15:0] clampg(input logic [15:0] g);
        return (g < `FCR_GAIN_MIN) ? `FCR_GAIN_MIN : ((g > `FCR_GAIN_MAX) ? `FCR_GAIN_MAX : g);
    endfunction
    // Expected frame: e picks exposure set, o the other set
    function automatic fcr_exp_t mk(input bit emb, input bit st, input int e, input int o);
        fcr_exp_t r;
        logic [15:0] ll, m, rows;
        ll = sv[o][`FCR_SET_LINE_LEN];
        m = sv[o][`FCR_SET_MODE];
        rows = (m[`FCR_MODE_Y_SKIP] | m[`FCR_MODE_ROW_BIN]) ? sv[o][`FCR_SET_ROWS] >> 1 : sv[o][`FCR_SET_ROWS];
        r[0] = emb ? `FCR_EXTRA_ROWS * ll : 16'h0000;
        r[1] = rows * ll;
        r[2] = st ? `FCR_EXTRA_ROWS * ll : 16'h0000;
        r[3] = sv[e][`FCR_SET_EXP];
        r[4] = ll;
        r[5] = clampg(sv[o][`FCR_SET_AGAIN]);
        r[6] = clampg(sv[o][hdr ? `FCR_SET_AGAIN_T1 : `FCR_SET_AGAIN]);
        r[7] = clampg(sv[o][`FCR_SET_DG_RED]);
        r[8] = clampg(sv[o][`FCR_SET_DG_BLUE]);
        r[9] = {11'h000, m[0], m[1], 1'b0, m[2], m[3]}; // colour part: summing stays off
        r[10] = 16'h0000;
        return r;
    endfunction
    task automatic cmp_reg(input string what, input logic [15:0] want, input logic [15:0] seen);
        cmp_count++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic cmp_frame(input fcr_exp_t want, input fcr_exp_t seen);
        for (int i = 0; i < 11; i++) begin
            cmp_reg(fn[i], want[i], seen[i]);
        end
    endtask

    // ==========
    // Register port driver; one idle cycle between requests
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] want);
        rdq.push_back(want);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    // One frame; an optional control write lands while it is read out
    task automatic frame(input fcr_exp_t want, input bit slave, input bit mid, input logic [15:0] ctl);
        int n;
        frq.push_back(want);
        if (slave) u_trig.fire(2, 3);
        n = 0;
        while (frame_start !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        if (mid) wr(`FCR_REG_CTRL, ctl);
        while (row_valid === 1'b1 && n < 600) begin
            @(posedge core_clk);
            n++;
        end
        repeat (24) @(posedge core_clk);
    endtask

    // ==========
    // Monitor: pops the oldest note when a read answer or a frame end shows
    always @(posedge core_clk) begin
        if (sys_rst) begin
            rd_seen = 1'b0;
            in_fr = 1'b0;
        end else begin
            if (rd_seen) cmp_reg("reg_rdata", (rdq.size() > 0) ? rdq.pop_front() : 16'hDEAD, reg_rdata);
            rd_seen = reg_rd;
            if (frame_start === 1'b1) begin
                cmp_reg("row_num", 16'h0000, row_num);
                cnt = '{default: 16'h0000};
                oerr = 16'h0000;
                lastk = FCR_ROW_NONE;
                in_fr = 1'b1;
            end
            if (row_valid === 1'b1) begin
                case (row_kind)
                    FCR_ROW_EMB: cnt[0] = cnt[0] + 16'h0001;
                    FCR_ROW_ACT: cnt[1] = cnt[1] + 16'h0001;
                    FCR_ROW_STAT: cnt[2] = cnt[2] + 16'h0001;
                    default: oerr = oerr + 16'h0001;
                endcase
                if (row_kind < lastk) oerr = oerr + 16'h0001; // Row kinds must never step back
                lastk = row_kind;
            end else if (in_fr) begin
                in_fr = 1'b0;
                got = {oerr, 11'h000, params.col_bin, params.row_bin, params.row_sum, params.x_skip,
                    params.y_skip, params.dgain[3], params.dgain[0], params.again_t1, params.again,
                    params.line_len, params.exp_rows, cnt[2], cnt[1], cnt[0]};
                if (frq.size() > 0) cmp_frame(frq.pop_front(), got);
                else cmp_reg("extra_frame", 16'h0000, 16'h0001);
            end
        end
    end

    // ==========
    // Verdict
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog: whole sequence needs about 450 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        close_out();
    end

    // ==========
    // Main sequence
    initial begin
        sv[0] = '{16'h0005, 16'h0003, 16'h0002, 16'h0004, 16'h0001, 16'h0020, 16'h0030, 16'h0011,
            16'h0015, 16'h0016, 16'h0044, 16'h0002};
        sv[1] = '{16'h0007, 16'h0004, 16'h0003, 16'h0002, 16'h0001, 16'h0200, 16'h0008, 16'h0022,
            16'h0025, 16'h0026, 16'h0033, 16'h001D};
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        cmp_reg("pll_mult_eff", `FCR_RST_PLL_MULT, pll_mult_eff);
        rd(`FCR_REG_PLL_MULT, `FCR_RST_PLL_MULT);
        // PLL stays in use; only the multiplier value changes
        wr(`FCR_REG_PLL_MULT, 16'h0021);
        @(posedge core_clk);
        cmp_reg("pll_mult_eff", 16'h0020, pll_mult_eff);
        rd(`FCR_REG_PLL_MULT, 16'h0021);
        wr(`FCR_REG_PLL_MULT, 16'h0024);
        @(posedge core_clk);
        cmp_reg("pll_mult_eff", 16'h0024, pll_mult_eff);
        rd(16'h000F, 16'h0000);
        t = xs();
        temp_code_in <= t;
        repeat (4) @(posedge core_clk);
        rd(`FCR_REG_TEMP_CODE, t);
        rd(`FCR_REG_TEMP_REF, 16'h0123);
        rd(`FCR_REG_TEMP_SLOPE, 16'h0045);
        // Context memory at its top words; writes step the address, reads do not
        r1 = xs();
        r2 = xs();
        wr(`FCR_REG_CTX_ADDR, 16'h00FE);
        wr(`FCR_REG_CTX_DATA, r1);
        wr(`FCR_REG_CTX_DATA, r2);
        wr(`FCR_REG_CTX_ADDR, 16'h00FE);
        rd(`FCR_REG_CTX_DATA, r1);
        rd(`FCR_REG_CTX_DATA, r1);
        wr(`FCR_REG_CTX_ADDR, 16'h00FF);
        rd(`FCR_REG_CTX_DATA, r2);
        // Same register list in both sets
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < FCR_NSET; i++) begin
                wr((s == 0 ? `FCR_REG_SET_A : `FCR_REG_SET_B) + 16'(i), sv[s][i]);
            end
        end
        wr(`FCR_REG_CTRL, 16'h003B);
        frame(mk(1, 1, 0, 0), 1, 0, 16'h0000);
        frame(mk(1, 1, 0, 0), 1, 1, 16'h003F);
        frame(mk(1, 1, 1, 0), 1, 0, 16'h0000);
        frame(mk(1, 1, 1, 1), 1, 1, 16'h003B);
        frame(mk(1, 1, 0, 1), 1, 0, 16'h0000);
        wr(`FCR_REG_CTRL, 16'h0023);
        frame(mk(0, 0, 0, 0), 1, 0, 16'h0000);
        // Master frame with line interleave off: both exposures share one gain
        hdr = 1'b0;
        wr(`FCR_REG_CTRL, 16'h0019);
        frame(mk(1, 1, 0, 0), 0, 1, 16'h0018);
        repeat (40) @(posedge core_clk);
        cmp_reg("frames_left", 16'h0000, 16'(frq.size()));
        close_out();
    end
endmodule // frame_context_readout_control_bench
